// File: core/sac_consts.svh
// register offsets, field positions, reset values and timing counts for sleep and clock gating
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH

// block bases (byte addresses) and register indices
`define SAC_SLEEP_BASE 8'h00
`define SAC_GATE_BASE 8'h40
`define SAC_IDX_SLEEP_CTRL 3'h0
`define SAC_IDX_GEN 3'h0
`define SAC_IDX_PA 3'h1
`define SAC_IDX_PB 3'h2
`define SAC_IDX_PC 3'h3
`define SAC_IDX_PF 3'h6
`define SAC_SEL_NONE 4'hf

// field layout of the sleep control register
`define SAC_SEN_BIT 0
`define SAC_MODE_LSB 1
`define SAC_MODE_MSB 3
`define SAC_SLEEP_MASK 8'h0f

// writable masks of the gate registers
`define SAC_GEN_MASK 8'h1f
`define SAC_AN_MASK 8'h07
`define SAC_PORT_MASK 8'h7f
`define SAC_DMA_BIT 0

// peripherals fitted to this part; bits of absent units stay zero
`define SAC_GEN_PRESENT 8'h1f
`define SAC_AN_PRESENT 8'h07
`define SAC_PORT_PRESENT 8'h7f

// reset values
`define SAC_RST_BYTE 8'h00
`define SAC_RST_WORD 32'h0000_0000

// ahb transfer type bit that marks NONSEQ or SEQ
`define SAC_HTRANS_ACTIVE 1

// halt after wake, in cpu cycles
`define SAC_WAKE_HALT_CYC 3'h4
`define SAC_CNT_ONE 3'h1
`define SAC_CNT_ZERO 3'h0

`endif

// File: core/sac_pkg.sv
// types shared by the sleep and clock gating block
`default_nettype none
package sac_pkg;
    typedef enum logic [2:0] {
        SAC_IDLE_MODE = 3'b000,
        SAC_RSVD1 = 3'b001,
        SAC_FULL_STOP_MODE = 3'b010,
        SAC_COUNTER_ALIVE_MODE = 3'b011,
        SAC_RSVD4 = 3'b100,
        SAC_RSVD5 = 3'b101,
        SAC_OSCILLATOR_ALIVE_MODE = 3'b110,
        SAC_OSCILLATOR_COUNTER_ALIVE_MODE = 3'b111
    } sac_mode_t;

    typedef enum logic [1:0] {
        SAC_ST_RUN = 2'b00,
        SAC_ST_SLEEP = 2'b01,
        SAC_ST_WAKE = 2'b10
    } sac_state_t;
endpackage : sac_pkg
`default_nettype wire

// File: core/sac_gate_filter.sv
// write filter for gate registers: masks reserved and absent bits, blocks dma gate while enabled
`default_nettype none
`include "sac_consts.svh"
module sac_gate_filter (
    input wire logic [7:0] cur_in,
    input wire logic [7:0] wdata_in,
    input wire logic [7:0] keep_mask_in,
    input wire logic dma_guard_in,
    input wire logic dma_enabled_in,
    output logic [7:0] next_value_out
);
    always_comb
    begin
        next_value_out = wdata_in & keep_mask_in;
        // the dma gate cannot be newly set while the controller runs
        if (dma_guard_in && dma_enabled_in && !cur_in[`SAC_DMA_BIT])
        begin
            next_value_out[`SAC_DMA_BIT] = 1'b0;
        end
    end
endmodule : sac_gate_filter
`default_nettype wire

// File: core/sac_sleep_fsm.sv
// sleep sequencer: entry on the sleep instruction, wake filtering, post-wake halt
`default_nettype none
`include "sac_consts.svh"
module sac_sleep_fsm (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic sleep_instr_in,
    input wire logic sleep_enable_bit_in,
    input wire logic [2:0] sleep_mode_select_in,
    input wire logic any_irq_in,
    input wire logic rtc_irq_in,
    input wire logic twi_match_in,
    input wire logic async_port_irq_in,
    output logic sleeping_out,
    output logic cpu_halt_out,
    output logic [4:0] stops_out
);
    sac_pkg::sac_state_t state;
    sac_pkg::sac_state_t next_state;
    sac_pkg::sac_mode_t mode;
    logic [2:0] halt_cnt;
    logic wake;

    function automatic logic sac_mode_legal(input logic [2:0] m);
        sac_mode_legal = !(m == sac_pkg::SAC_RSVD1 || m == sac_pkg::SAC_RSVD4
            || m == sac_pkg::SAC_RSVD5);
    endfunction : sac_mode_legal

    // stops: {rtc osc, sys osc, rtc clk, periph clk, cpu clk}
    function automatic logic [4:0] sac_stops(input sac_pkg::sac_state_t s,
                                             input sac_pkg::sac_mode_t m);
        sac_stops = 5'h00;
        if (s == sac_pkg::SAC_ST_SLEEP)
        begin
            unique case (m)
                sac_pkg::SAC_IDLE_MODE: sac_stops = 5'h01;
                sac_pkg::SAC_FULL_STOP_MODE: sac_stops = 5'h1f;
                sac_pkg::SAC_COUNTER_ALIVE_MODE: sac_stops = 5'h0b;
                sac_pkg::SAC_OSCILLATOR_ALIVE_MODE: sac_stops = 5'h17;
                sac_pkg::SAC_OSCILLATOR_COUNTER_ALIVE_MODE: sac_stops = 5'h03;
                default: sac_stops = 5'h00;
            endcase
        end
    endfunction : sac_stops

    // only asynchronous sources reach a sleeping core with its clocks stopped
    always_comb
    begin
        unique case (mode)
            sac_pkg::SAC_IDLE_MODE: wake = any_irq_in;
            sac_pkg::SAC_COUNTER_ALIVE_MODE,
            sac_pkg::SAC_OSCILLATOR_COUNTER_ALIVE_MODE:
                wake = twi_match_in || async_port_irq_in || rtc_irq_in;
            default: wake = twi_match_in || async_port_irq_in;
        endcase
    end

    always_comb
    begin
        next_state = state;
        unique case (state)
            sac_pkg::SAC_ST_RUN:
                // reserved codes leave the instruction without effect
                if (sleep_instr_in && sleep_enable_bit_in
                    && sac_mode_legal(sleep_mode_select_in))
                begin
                    next_state = sac_pkg::SAC_ST_SLEEP;
                end
            sac_pkg::SAC_ST_SLEEP:
                if (wake)
                begin
                    next_state = sac_pkg::SAC_ST_WAKE;
                end
            sac_pkg::SAC_ST_WAKE:
                if (halt_cnt == `SAC_CNT_ONE)
                begin
                    next_state = sac_pkg::SAC_ST_RUN;
                end
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state <= sac_pkg::SAC_ST_RUN;
            mode <= sac_pkg::SAC_IDLE_MODE;
            halt_cnt <= `SAC_CNT_ZERO;
            sleeping_out <= 1'b0;
            cpu_halt_out <= 1'b0;
            stops_out <= 5'h00;
        end
        else if (ce_in)
        begin
            state <= next_state;
            if (state == sac_pkg::SAC_ST_RUN)
            begin
                mode <= sac_pkg::sac_mode_t'(sleep_mode_select_in);
            end
            if (next_state == sac_pkg::SAC_ST_WAKE && state == sac_pkg::SAC_ST_SLEEP)
            begin
                halt_cnt <= `SAC_WAKE_HALT_CYC;
            end
            else if (halt_cnt != `SAC_CNT_ZERO)
            begin
                halt_cnt <= halt_cnt - `SAC_CNT_ONE;
            end
            sleeping_out <= (next_state == sac_pkg::SAC_ST_SLEEP);
            cpu_halt_out <= (next_state != sac_pkg::SAC_ST_RUN);
            stops_out <= sac_stops(next_state, (state == sac_pkg::SAC_ST_RUN)
                ? sac_pkg::sac_mode_t'(sleep_mode_select_in) : mode);
        end
    end

    // =========================================
    // checks
    a_wake_halt_four: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        ($fell(sleeping_out) && ce_in) |-> cpu_halt_out [*4] ##1 !cpu_halt_out)
        else $error("halt after wake is not four cycles");
    a_full_stop_mode_all_stop: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (sleeping_out && mode == sac_pkg::SAC_FULL_STOP_MODE) |-> stops_out == 5'h1f)
        else $error("power-down leaves a clock running");
    a_full_stop_mode_wake_src: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (sleeping_out && ce_in && mode == sac_pkg::SAC_FULL_STOP_MODE
         && !twi_match_in && !async_port_irq_in) |=> sleeping_out)
        else $error("power-down woken by a synchronous source");
    a_idle_periph_on: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (sleeping_out && mode == sac_pkg::SAC_IDLE_MODE) |-> stops_out == 5'h01)
        else $error("idle stops more than the cpu clock");
    c_sleep_entry: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        $rose(sleeping_out));
    c_wake_done: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        $fell(cpu_halt_out));
endmodule : sac_sleep_fsm
`default_nettype wire

// File: core/sac_top.sv
// sleep mode control and per-peripheral clock gating, registers on ahb-lite
// =========================================
//
// Implementation choice: the AHB-Lite interface to the registers.
`default_nettype none
`include "sac_consts.svh"
module sac_top (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic hreadyout_out,
    output logic hresp_out,
    output logic [31:0] hrdata_out,
    input wire logic sleep_instr_in,
    input wire logic dma_enabled_in,
    input wire logic any_irq_in,
    input wire logic rtc_irq_in,
    input wire logic twi_match_in,
    input wire logic async_port_irq_in,
    output logic sleep_enable_bit_out,
    output logic [2:0] sleep_mode_select_out,
    output logic sleeping_out,
    output logic cpu_halt_out,
    output logic cpu_clk_stop_out,
    output logic periph_clk_stop_out,
    output logic rtc_clk_stop_out,
    output logic sys_osc_stop_out,
    output logic rtc_osc_stop_out,
    output logic [4:0] general_clock_gate_out,
    output logic [2:0] analog_port_a_clock_gate_out,
    output logic [2:0] analog_port_b_clock_gate_out,
    output logic [6:0] port_c_clock_gate_out,
    output logic [6:0] port_d_clock_gate_out,
    output logic [6:0] port_e_clock_gate_out,
    output logic [6:0] port_f_clock_gate_out
);
    // =========================================
    // register storage
    logic [7:0] sleep_control;
    logic [7:0] gate_regs [0:6];
    logic dp_write;
    logic dp_read;
    logic [3:0] dp_sel;
    logic [3:0] ap_sel;
    logic [7:0] next_gate;
    logic [7:0] gate_keep;
    logic [4:0] stops;

    // maps a byte address to 0 (sleep control), 1..7 (gate index + 1) or none
    function automatic logic [3:0] sac_decode(input logic [31:0] addr);
        sac_decode = `SAC_SEL_NONE;
        if (addr[31:8] == 24'h00_0000 && addr[1:0] == 2'b00)
        begin
            if (addr[7:0] == `SAC_SLEEP_BASE + {3'h0, `SAC_IDX_SLEEP_CTRL, 2'b00})
            begin
                sac_decode = 4'h0;
            end
            else if (addr[7:5] == `SAC_GATE_BASE >> 5 && addr[4:2] <= `SAC_IDX_PF)
            begin
                sac_decode = {1'b0, addr[4:2]} + 4'h1;
            end
        end
    endfunction : sac_decode

    // writable and fitted bits of each gate register
    function automatic logic [7:0] sac_keep(input logic [2:0] idx);
        if (idx == `SAC_IDX_GEN)
        begin
            sac_keep = `SAC_GEN_MASK & `SAC_GEN_PRESENT;
        end
        else if (idx == `SAC_IDX_PA || idx == `SAC_IDX_PB)
        begin
            sac_keep = `SAC_AN_MASK & `SAC_AN_PRESENT;
        end
        else
        begin
            sac_keep = `SAC_PORT_MASK & `SAC_PORT_PRESENT;
        end
    endfunction : sac_keep

    assign ap_sel = sac_decode(haddr_in);

    // =========================================
    // ahb-lite address and data phases
    // reads take one wait state so that a write just before is seen
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            dp_write <= 1'b0;
            dp_read <= 1'b0;
            dp_sel <= `SAC_SEL_NONE;
        end
        else if (ce_in)
        begin
            if (hready_in)
            begin
                dp_write <= hsel_in && htrans_in[`SAC_HTRANS_ACTIVE] && hwrite_in;
                dp_read <= hsel_in && htrans_in[`SAC_HTRANS_ACTIVE] && !hwrite_in;
                dp_sel <= ap_sel;
            end
            else
            begin
                dp_write <= 1'b0;
                dp_read <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
            hrdata_out <= `SAC_RST_WORD;
        end
        else if (ce_in)
        begin
            hresp_out <= 1'b0;
            if (hready_in && hsel_in && htrans_in[`SAC_HTRANS_ACTIVE] && !hwrite_in)
            begin
                hreadyout_out <= 1'b0;
            end
            else if (dp_read)
            begin
                hreadyout_out <= 1'b1;
                if (dp_sel == 4'h0)
                begin
                    hrdata_out <= {24'h00_0000, sleep_control};
                end
                else if (dp_sel == `SAC_SEL_NONE)
                begin
                    hrdata_out <= `SAC_RST_WORD;
                end
                else
                begin
                    hrdata_out <= {24'h00_0000, gate_regs[dp_sel[2:0] - 3'h1]};
                end
            end
        end
    end

    // =========================================
    // sleep control register
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            sleep_control <= `SAC_RST_BYTE;
        end
        else if (ce_in && dp_write && dp_sel == 4'h0)
        begin
            sleep_control <= hwdata_in[7:0] & `SAC_SLEEP_MASK;
        end
    end

    // =========================================
    // gate registers
    assign gate_keep = sac_keep(dp_sel[2:0] - 3'h1);

    sac_gate_filter u_filter (
        .cur_in(gate_regs[dp_sel[2:0] - 3'h1]),
        .wdata_in(hwdata_in[7:0]),
        .keep_mask_in(gate_keep),
        .dma_guard_in(dp_sel == 4'h1),
        .dma_enabled_in(dma_enabled_in),
        .next_value_out(next_gate)
    );

    // a cleared gate bit only re-enables the clock; unit state is held by
    // the unit itself, so event system and timers resume where they stopped
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            for (int i = 0; i < 7; i++)
            begin
                gate_regs[i] <= `SAC_RST_BYTE;
            end
        end
        else if (ce_in && dp_write && dp_sel != 4'h0 && dp_sel != `SAC_SEL_NONE)
        begin
            gate_regs[dp_sel[2:0] - 3'h1] <= next_gate;
        end
    end

    // =========================================
    // sleep sequencing
    sac_sleep_fsm u_fsm (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .sleep_instr_in(sleep_instr_in),
        .sleep_enable_bit_in(sleep_control[`SAC_SEN_BIT]),
        .sleep_mode_select_in(sleep_control[`SAC_MODE_MSB:`SAC_MODE_LSB]),
        .any_irq_in(any_irq_in),
        .rtc_irq_in(rtc_irq_in),
        .twi_match_in(twi_match_in),
        .async_port_irq_in(async_port_irq_in),
        .sleeping_out(sleeping_out),
        .cpu_halt_out(cpu_halt_out),
        .stops_out(stops)
    );

    // =========================================
    // outputs straight from flip-flops
    // the per-unit stop bits also tell each unit to freeze and to refuse
    // register access while its clock is off
    assign sleep_enable_bit_out = sleep_control[`SAC_SEN_BIT];
    assign sleep_mode_select_out = sleep_control[`SAC_MODE_MSB:`SAC_MODE_LSB];
    assign cpu_clk_stop_out = stops[0];
    assign periph_clk_stop_out = stops[1];
    assign rtc_clk_stop_out = stops[2];
    assign sys_osc_stop_out = stops[3];
    assign rtc_osc_stop_out = stops[4];
    assign general_clock_gate_out = gate_regs[0][4:0];
    assign analog_port_a_clock_gate_out = gate_regs[1][2:0];
    assign analog_port_b_clock_gate_out = gate_regs[2][2:0];
    assign port_c_clock_gate_out = gate_regs[3][6:0];
    assign port_d_clock_gate_out = gate_regs[4][6:0];
    assign port_e_clock_gate_out = gate_regs[5][6:0];
    assign port_f_clock_gate_out = gate_regs[6][6:0];

    // =========================================
    // checks
    a_no_sleep_disabled: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (!sleeping_out && !sleep_control[`SAC_SEN_BIT]) |=> !sleeping_out)
        else $error("sleep entered with enable clear");
    a_sleep_on_instr: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (ce_in && !cpu_halt_out && sleep_instr_in && sleep_control[`SAC_SEN_BIT]
         && sleep_control[`SAC_MODE_MSB:`SAC_MODE_LSB] == 3'b110) |=> sleeping_out)
        else $error("sleep instruction with enable set did not sleep");
    a_ctrl_rsvd_zero: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        ($rose(hreadyout_out) && dp_sel == 4'h0) |-> hrdata_out[31:4] == 28'h0)
        else $error("sleep control reserved bits read nonzero");
    a_gate_rsvd_zero: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (ce_in && dp_write && dp_sel == 4'h4) |=> gate_regs[3][7] == 1'b0)
        else $error("port gate reserved bit stored");
    a_dma_set_blocked: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (ce_in && dp_write && dp_sel == 4'h1 && dma_enabled_in && hwdata_in[0]
         && !gate_regs[0][0]) |=> !general_clock_gate_out[0])
        else $error("dma gate set while dma enabled");
    a_gen_write_takes: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (ce_in && dp_write && dp_sel == 4'h1 && !dma_enabled_in)
        |=> general_clock_gate_out == $past(hwdata_in[4:0]))
        else $error("general gate write lost");
    a_read_one_wait: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (ce_in && hready_in && hsel_in && htrans_in[1] && !hwrite_in) ##1 ce_in
        |=> hreadyout_out ##0 !$past(hreadyout_out))
        else $error("read answer not after one wait state");
    c_dma_blocked: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        ce_in && dp_write && dp_sel == 4'h1 && dma_enabled_in && hwdata_in[0]);
    c_full_stop_mode_sleep: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        sleeping_out && sys_osc_stop_out);
    c_gate_read: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        $rose(hreadyout_out) && dp_sel == 4'h4);
endmodule : sac_top
`default_nettype wire

// File: tb/sac_core_model.sv
// behavioural processor core that executes the sleep instruction on request
`default_nettype none
module sac_core_model (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic go_in,
    input wire logic halt_in,
    output logic sleep_instr_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // =========================================
    // instruction issue
    // a halted core fetches nothing, so a request made while halted is lost
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            sleep_instr_out <= 1'b0;
        else
            sleep_instr_out <= go_in && !halt_in && !sleep_instr_out;
    end
endmodule : sac_core_model
`default_nettype wire

// File: tb/sleep_and_clock_gating_bench.sv
// self-checking bench for sleep control and clock gating registers
`default_nettype none
`include "sac_consts.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module sleep_and_clock_gating_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys_in = 1'b0, rst_n_in = 1'b0, ce_in = 1'b1, hsel_in = 1'b0, hwrite_in = 1'b0;
    logic [31:0] haddr_in = 32'h0, hwdata_in = 32'h0, hrdata_out, rd, seed = 32'h0000_0022;
    logic [1:0] htrans_in = 2'h0;
    logic dma_enabled_in = 1'b0, any_irq_in = 1'b0, rtc_irq_in = 1'b0, twi_match_in = 1'b0;
    logic async_port_irq_in = 1'b0, go = 1'b0, sleep_instr, hreadyout_out, hresp_out;
    logic sleep_enable_bit_out, sleeping_out, cpu_halt_out, cpu_clk_stop_out;
    logic periph_clk_stop_out, rtc_clk_stop_out, sys_osc_stop_out, rtc_osc_stop_out;
    logic [2:0] sleep_mode_select_out, analog_port_a_clock_gate_out, analog_port_b_clock_gate_out;
    logic [4:0] general_clock_gate_out;
    logic [6:0] port_c_clock_gate_out, port_d_clock_gate_out;
    logic [6:0] port_e_clock_gate_out, port_f_clock_gate_out;
    logic [7:0] exp_reg [0:7];
    int fail_count = 0, total_checks = 0, cycles = 0, n;
    sac_top uut (.clk_sys_in, .rst_n_in, .ce_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in,
        .hsize_in(3'h2), .hwdata_in, .hready_in(hreadyout_out), .hreadyout_out, .hresp_out,
        .hrdata_out, .sleep_instr_in(sleep_instr), .dma_enabled_in, .any_irq_in, .rtc_irq_in,
        .twi_match_in, .async_port_irq_in, .sleep_enable_bit_out, .sleep_mode_select_out,
        .sleeping_out, .cpu_halt_out, .cpu_clk_stop_out, .periph_clk_stop_out,
        .rtc_clk_stop_out, .sys_osc_stop_out, .rtc_osc_stop_out, .general_clock_gate_out,
        .analog_port_a_clock_gate_out, .analog_port_b_clock_gate_out, .port_c_clock_gate_out,
        .port_d_clock_gate_out, .port_e_clock_gate_out, .port_f_clock_gate_out);
    sac_core_model core (.clk_in(clk_sys_in), .rst_n_in, .go_in(go), .halt_in(cpu_halt_out),
        .sleep_instr_out(sleep_instr));
    // =========================================
    // clock and timeout
    initial
    begin
        forever #50 clk_sys_in = ~clk_sys_in;
    end
    always @(posedge clk_sys_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            test_done();
        end
    end
    // =========================================
    // helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    function automatic logic [31:0] addr_of(input int k);
        return (k == 0) ? {24'h0, `SAC_SLEEP_BASE} : {24'h0, `SAC_GATE_BASE} + 32'(4 * (k - 1));
    endfunction : addr_of
    function automatic logic [7:0] mask_of(input int k);
        return (k == 0) ? `SAC_SLEEP_MASK : (k == 1) ? `SAC_GEN_MASK :
            (k < 4) ? `SAC_AN_MASK : `SAC_PORT_MASK;
    endfunction : mask_of
    function automatic logic [7:0] gate_out(input int k);
        case (k)
            1: return {3'h0, general_clock_gate_out};
            2: return {5'h0, analog_port_a_clock_gate_out};
            3: return {5'h0, analog_port_b_clock_gate_out};
            4: return {1'h0, port_c_clock_gate_out};
            5: return {1'h0, port_d_clock_gate_out};
            6: return {1'h0, port_e_clock_gate_out};
            default: return {1'h0, port_f_clock_gate_out};
        endcase
    endfunction : gate_out
    // stops as {cpu, periph, rtc clk, sys osc, rtc osc}
    function automatic logic [4:0] exp_stops(input int m);
        case (m)
            0: return 5'h10;
            2: return 5'h1f;
            3: return 5'h1a;
            6: return 5'h1d;
            default: return 5'h18;
        endcase
    endfunction : exp_stops
    // single ahb transfer; entered just after a rising edge
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel_in <= 1'b1;
        haddr_in <= a;
        hwrite_in <= w;
        htrans_in <= 2'h2;
        do @(posedge clk_sys_in); while (hreadyout_out !== 1'b1);
        htrans_in <= 2'h0;
        hwdata_in <= d;
        do @(posedge clk_sys_in); while (hreadyout_out !== 1'b1);
        rd = hrdata_out;
    endtask : bus
    task automatic fire();
        go <= 1'b1;
        @(posedge clk_sys_in);
        go <= 1'b0;
        repeat (3) @(negedge clk_sys_in);
        @(posedge clk_sys_in);
    endtask : fire
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done
    // =========================================
    // main sequence
    initial
    begin
        repeat (16) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        @(posedge clk_sys_in);
        // index 8 is an unmapped hole past the gate block
        for (int k = 0; k < 9; k++)
        begin
            bus(1'b0, (k < 8) ? addr_of(k) : 32'h0000_0080, 32'h0);
            `CHK(rd, 32'h0)
        end
        $display("test reset done");
        for (int k = 0; k < 8; k++)
        begin
            rd = rnd();
            exp_reg[k] = rd[7:0] & mask_of(k);
            // no live unit sits behind a gate, so reinit and disable duties hold
            bus(1'b1, addr_of(k), rd);
        end
        for (int k = 0; k < 8; k++)
        begin
            bus(1'b0, addr_of(k), 32'h0);
            `CHK(rd, {24'h0, exp_reg[k]})
            if (k > 0)
                `CHK(gate_out(k), exp_reg[k])
        end
        `CHK({sleep_mode_select_out, sleep_enable_bit_out}, exp_reg[0][3:0])
        $display("test gates done");
        dma_enabled_in <= 1'b1;
        bus(1'b1, addr_of(1), 32'h0);
        bus(1'b1, addr_of(1), 32'h0000_001f);
        bus(1'b0, addr_of(1), 32'h0);
        `CHK(rd, 32'h0000_001e)
        dma_enabled_in <= 1'b0;
        bus(1'b1, addr_of(1), 32'h0000_0001);
        bus(1'b0, addr_of(1), 32'h0);
        `CHK(rd, 32'h0000_0001)
        `CHK(general_clock_gate_out, 5'h01)
        // a write made while the clock enable is low must leave no trace
        ce_in <= 1'b0;
        bus(1'b1, addr_of(1), 32'h0000_001e);
        ce_in <= 1'b1;
        bus(1'b0, addr_of(1), 32'h0);
        `CHK(rd, 32'h0000_0001)
        $display("test dma done");
        bus(1'b1, addr_of(0), 32'h0);
        fire();
        `CHK(sleeping_out, 1'b0)
        for (int m = 0; m < 8; m++)
        begin
            bus(1'b1, addr_of(0), {28'h0, 3'(m), 1'b1});
            fire();
            `CHK(sleeping_out, 1'(m inside {0, 2, 3, 6, 7}))
            if (m inside {0, 2, 3, 6, 7})
            begin
                `CHK({cpu_clk_stop_out, periph_clk_stop_out, rtc_clk_stop_out,
                    sys_osc_stop_out, rtc_osc_stop_out}, exp_stops(m))
                any_irq_in <= 1'b1;
                rtc_irq_in <= 1'b1;
                n = 0;
                // count the settled cycles that show the core halted but awake
                repeat (3)
                begin
                    @(negedge clk_sys_in);
                    n += int'(cpu_halt_out === 1'b1 && sleeping_out === 1'b0);
                end
                `CHK(sleeping_out, 1'(m inside {2, 6}))
                @(posedge clk_sys_in);
                async_port_irq_in <= 1'b1;
                while (cpu_halt_out === 1'b1)
                begin
                    @(negedge clk_sys_in);
                    n += int'(cpu_halt_out === 1'b1 && sleeping_out === 1'b0);
                end
                `CHK(n, 4)
                @(posedge clk_sys_in);
                {any_irq_in, rtc_irq_in, async_port_irq_in} <= 3'h0;
                bus(1'b1, addr_of(0), 32'h0);
            end
            $display("test sleep mode %0d done", m);
        end
        test_done();
    end
endmodule : sleep_and_clock_gating_bench
`default_nettype wire
